// [fetx_pkg.sv]
// Purpose: Shared constants, types and code-group tables of the transmit coding path
// Assumes: One code-group is five line bits, sent most significant bit first
// Notes:   Code-group values, field widths, taps and the upper seed bits that the logic uses are named here
package fetx_pkg;

	localparam int NIB_W      = 4;
	localparam int GRP_W      = 5;
	localparam int ENTRY_W    = NIB_W + 1;
	localparam int FIFO_DEPTH = 32;
	localparam int LFSR_W     = 11;
	localparam int STRAP_W    = 5;

	localparam logic [2:0] BIT_LAST = 3'h4;

	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J    = 5'h18;
	localparam logic [4:0] CG_K    = 5'h11;
	localparam logic [4:0] CG_T    = 5'h0D;
	localparam logic [4:0] CG_R    = 5'h07;
	localparam logic [4:0] CG_HALT = 5'h04;

	localparam logic [3:0] NIB_SSD  = 4'h5;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// Data code-groups, indexed by nibble value
	localparam logic [4:0] CG_DATA [16] = '{
		5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
	};

	// Feedback taps of x^11 + x^9 + 1
	localparam int LFSR_TAP_A = 10;
	localparam int LFSR_TAP_B = 8;
	// Upper seed bits kept nonzero so the register never locks at all zeros
	localparam logic [6:0] SEED_UPPER = 7'h5A;

	localparam logic [1:0] MLT_POS = 2'h1;
	localparam logic [1:0] MLT_NEG = 2'h3;

	typedef enum logic [2:0] {
		FETX_ST_IDLE,
		FETX_ST_SSD_K,
		FETX_ST_DATA,
		FETX_ST_ESD_T,
		FETX_ST_ESD_R
	} fetx_state_t;

	typedef struct packed {
		logic             invalid;
		logic             control;
		logic [NIB_W-1:0] nibble;
	} fetx_dec_t;

	function automatic logic [GRP_W-1:0] fetx_encode(input logic [NIB_W-1:0] nib);
		return CG_DATA[nib];
	endfunction

	function automatic fetx_dec_t fetx_decode(input logic [GRP_W-1:0] cg);
		fetx_dec_t r;
		r.invalid = 1'b1;
		r.control = 1'b0;
		r.nibble  = NIB_ZERO;
		for (int i = 0; i < 16; i++) begin
			if (CG_DATA[i] == cg) begin
				r.invalid = 1'b0;
				r.nibble  = NIB_W'(i);
			end
		end
		if (cg == CG_IDLE || cg == CG_T || cg == CG_R) begin
			r.invalid = 1'b0;
			r.control = 1'b1;
			r.nibble  = NIB_ZERO;
		end
		if (cg == CG_J || cg == CG_K) begin
			r.invalid = 1'b0;
			r.control = 1'b1;
			r.nibble  = NIB_SSD;
		end
		if (cg == CG_HALT) begin
			r.control = 1'b1;
		end
		return r;
	endfunction

endpackage

// [fetx_fifo_if.sv]
// Purpose: Carrier between the MII sampler, the nibble buffer and the encoder
// Assumes: Valid and ready handshake on both sides, one clock
// Notes:   A word moves on any rising clock edge with valid and ready both high
`timescale 1ns/1ps
interface fetx_fifo_if #(
	parameter int W = 5
);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport buffer (
		input  in_valid,
		output in_ready,
		input  in_data,
		output out_valid,
		input  out_ready,
		output out_data
	);
	modport user (
		output in_valid,
		input  in_ready,
		output in_data,
		input  out_valid,
		output out_ready,
		input  out_data
	);
endinterface

// [fetx_fifo.sv]
// Purpose: Nibble buffer between the MII sampling side and the symbol side
// Assumes: Same clock on both sides, synchronous active high reset
// Notes:   Full and empty come from a true occupancy count
`timescale 1ns/1ps
module fetx_fifo #(
	parameter int W     = 5,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic     sys_clk,
	input wire logic     rst,
	// Both sides
	fetx_fifo_if.buffer  fi
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	logic          push;
	logic          pop;

	assign fi.in_ready  = (count_q != (AW+1)'(DEPTH));
	assign fi.out_valid = (count_q != '0);
	assign fi.out_data  = mem[rd_ptr_q];
	assign push         = fi.in_valid & fi.in_ready;
	assign pop          = fi.out_valid & fi.out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= fi.in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end

endmodule

// [fetx_top.sv]
// Purpose: 100 Mb/s transmit coding path, MII nibbles to two MLT-3 phase streams
// Assumes: sys_clk runs at BIT_CYCLES clocks per symbol bit; MII clock and pins are asynchronous to it
// Notes:   Scrambler bypass and address straps are pins; no software registers
`timescale 1ns/1ps

module fetx_top
	import fetx_pkg::*;
#(
	parameter int BIT_CYCLES = 1,
	parameter int DEPTH      = fetx_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                            sys_clk,
	input  wire logic                            rst,
	// MAC transmit side
	input  wire logic                            mii_tx_clk,
	input  wire logic [fetx_pkg::NIB_W-1:0]      mii_txd,
	input  wire logic                            mii_tx_en,
	// Straps and options
	input  wire logic [fetx_pkg::STRAP_W-1:0]    strap_address_input,
	input  wire logic                            scramble_bypass,
	// Line driver phases
	output logic                                 tx_drive_pos,
	output logic                                 tx_drive_neg,
	// Status
	output logic                                 fifo_overrun,
	output logic [fetx_pkg::NIB_W-1:0]           check_nibble,
	output logic                                 check_invalid,
	output logic                                 check_error
);
	import fetx_pkg::*;

	localparam int DIV_W = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [NIB_W+1:0]   mii_s1_q;
	logic [NIB_W+1:0]   mii_s2_q;
	logic               mii_clk_s3_q;
	logic [STRAP_W:0]   opt_s1_q;
	logic [STRAP_W:0]   opt_s2_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mii_s1_q <= '0;
			mii_s2_q <= '0;
		end else begin
			// Clock and data share one stage so they stay in step
			mii_s1_q <= {mii_tx_clk, mii_tx_en, mii_txd};
			mii_s2_q <= mii_s1_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mii_clk_s3_q <= 1'b0;
		end else begin
			mii_clk_s3_q <= mii_s2_q[NIB_W+1];
		end
	end

	always_ff @(posedge sys_clk) begin
		// No reset here: the straps must reach the seed load while reset is held
		opt_s1_q <= {scramble_bypass, strap_address_input};
		opt_s2_q <= opt_s1_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// MII sampling into the buffer

	fetx_fifo_if #(.W(ENTRY_W)) fq ();

	// Falling edge of the MII clock sits mid-nibble, away from MAC launch
	logic mii_fall;
	assign mii_fall = mii_clk_s3_q & ~mii_s2_q[NIB_W+1];

	assign fq.in_valid = mii_fall;
	assign fq.in_data  = mii_s2_q[NIB_W:0];

	fetx_fifo #(
		.W     (ENTRY_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.fi      (fq.buffer)
	);

	// The MAC cannot be stalled, so a refused nibble is a sticky fault
	logic overrun_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (fq.in_valid && !fq.in_ready) begin
			overrun_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bit pacing and code-group slots

	logic [DIV_W-1:0] div_q;
	logic             bit_tick;
	logic [2:0]       bit_cnt_q;
	logic             slot_end;

	// Each bit lasts BIT_CYCLES clocks; a slot is five bits
	assign bit_tick = (div_q == DIV_W'(BIT_CYCLES - 1));
	assign slot_end = bit_tick & (bit_cnt_q == BIT_LAST);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_q <= '0;
		end else begin
			div_q <= bit_tick ? '0 : div_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bit_cnt_q <= '0;
		end else if (bit_tick) begin
			bit_cnt_q <= (bit_cnt_q == BIT_LAST) ? '0 : bit_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit sequencer

	fetx_state_t      state_q;
	fetx_state_t      state_d;
	logic [GRP_W-1:0] grp_d;
	logic             in_data_d;
	logic             take;
	logic             f_en;
	logic [NIB_W-1:0] f_nib;
	logic             idle_drop;

	assign f_en          = fq.out_data[NIB_W];
	assign f_nib         = fq.out_data[NIB_W-1:0];
	// Gap entries met in idle are thrown away at once; waiting for a slot would let a
	// nibble clock faster than the slot rate fill the buffer between frames
	assign idle_drop     = (state_q == FETX_ST_IDLE) & fq.out_valid & ~f_en;
	assign fq.out_ready  = (take & slot_end) | idle_drop;

	always_comb begin
		state_d   = state_q;
		grp_d     = CG_IDLE;
		in_data_d = 1'b0;
		take      = 1'b0;
		unique case (state_q)
			FETX_ST_IDLE: begin
				grp_d = CG_IDLE;
				take  = fq.out_valid;
				if (fq.out_valid && f_en) begin
					grp_d   = CG_J;
					state_d = FETX_ST_SSD_K;
				end
			end
			FETX_ST_SSD_K: begin
				// An empty buffer still gets its K; the data slot then halts
				grp_d   = CG_K;
				take    = fq.out_valid;
				state_d = (fq.out_valid && !f_en) ? FETX_ST_ESD_T : FETX_ST_DATA;
			end
			FETX_ST_DATA: begin
				in_data_d = 1'b1;
				take      = fq.out_valid;
				if (!fq.out_valid) begin
					// Buffer ran dry mid-frame: mark the slot as an error
					grp_d = CG_HALT;
				end else if (f_en) begin
					grp_d = fetx_encode(f_nib);
				end else begin
					in_data_d = 1'b0;
					grp_d     = CG_T;
					state_d   = FETX_ST_ESD_R;
				end
			end
			FETX_ST_ESD_T: begin
				grp_d   = CG_T;
				state_d = FETX_ST_ESD_R;
			end
			FETX_ST_ESD_R: begin
				grp_d   = CG_R;
				state_d = FETX_ST_IDLE;
			end
			// Three unused codes of the state register recover to idle
			default: begin
				state_d = FETX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= FETX_ST_IDLE;
		end else if (slot_end) begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serialiser

	logic [GRP_W-1:0] shift_q;
	logic             nrz;

	assign nrz = shift_q[GRP_W-1];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shift_q <= CG_IDLE;
		end else if (slot_end) begin
			// Load replaces the last shift, so no gap opens between groups
			shift_q <= grp_d;
		end else if (bit_tick) begin
			shift_q <= {shift_q[GRP_W-2:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Self-check decode of each group as it is loaded

	fetx_dec_t dec;
	assign dec = fetx_decode(grp_d);

	logic [NIB_W-1:0] chk_nib_q;
	logic             chk_inv_q;
	logic             chk_err_q;
	logic             ctl_in_data;

	// A control group standing where data belongs
	assign ctl_in_data = in_data_d & dec.control;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chk_nib_q <= NIB_ZERO;
			chk_inv_q <= 1'b0;
			chk_err_q <= 1'b0;
		end else if (slot_end) begin
			chk_nib_q <= ctl_in_data ? NIB_ZERO : dec.nibble;
			chk_inv_q <= dec.invalid | ctl_in_data;
			chk_err_q <= ctl_in_data | (grp_d == CG_HALT);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scrambler

	logic [LFSR_W-1:0] lfsr_q;
	logic              key;
	logic              scr;

	assign key = lfsr_q[LFSR_TAP_A] ^ lfsr_q[LFSR_TAP_B];
	// Bypass sends the encoded stream as is
	assign scr = opt_s2_q[STRAP_W] ? nrz : (nrz ^ key);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// Straps settle through the synchroniser while reset is held
			lfsr_q <= {SEED_UPPER, opt_s2_q[STRAP_W-1:1]};
		end else if (bit_tick) begin
			lfsr_q <= {lfsr_q[LFSR_W-2:0], key};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// NRZI and MLT-3 phase split

	logic       nrzi_q;
	logic       nrzi_prev_q;
	logic [1:0] mlt_q;
	logic       pos_q;
	logic       neg_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nrzi_q <= 1'b0;
		end else if (bit_tick && scr) begin
			nrzi_q <= ~nrzi_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nrzi_prev_q <= 1'b0;
		end else begin
			nrzi_prev_q <= nrzi_q;
		end
	end

	// Phase steps one cycle after the toggle, so both phases leave flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mlt_q <= '0;
		end else if (nrzi_q != nrzi_prev_q) begin
			mlt_q <= mlt_q + 1'b1;
		end
	end

	// Of the line signals only the two phases leave the block; no binary line mode exists
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			pos_q <= (mlt_q == MLT_POS);
			neg_q <= (mlt_q == MLT_NEG);
		end
	end

	assign tx_drive_pos  = pos_q;
	assign tx_drive_neg  = neg_q;
	assign fifo_overrun  = overrun_q;
	assign check_nibble  = chk_nib_q;
	assign check_invalid = chk_inv_q;
	assign check_error   = chk_err_q;

endmodule

// [fetx_properties.sv]
// Purpose: Port-level checks on the transmit coding path
// Assumes: One clock domain, synchronous active high reset
// Notes:   Bound to every fetx_top instance at the file foot
`timescale 1ns/1ps
module fetx_properties
	import fetx_pkg::*;
(
	// Clock and reset
	input wire logic                       sys_clk,
	input wire logic                       rst,
	// Line and status
	input wire logic                       tx_drive_pos,
	input wire logic                       tx_drive_neg,
	input wire logic                       fifo_overrun,
	input wire logic [fetx_pkg::NIB_W-1:0] check_nibble,
	input wire logic                       check_invalid,
	input wire logic                       check_error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Polarity of the last pulse; phase restarts at zero heading positive
	logic last_neg_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_neg_q <= 1'b1;
		end else if (tx_drive_pos) begin
			last_neg_q <= 1'b0;
		end else if (tx_drive_neg) begin
			last_neg_q <= 1'b1;
		end
	end

	////////////////////////////////////////
	a_phase_exclusive: assert property (!(tx_drive_pos && tx_drive_neg))
		else $error("both line phases driven");
	a_pos_after_neg: assert property ($rose(tx_drive_pos) |-> last_neg_q)
		else $error("positive pulse without negative before");
	a_neg_after_pos: assert property ($rose(tx_drive_neg) |-> !last_neg_q)
		else $error("negative pulse without positive before");
	a_zero_after_pos: assert property ($fell(tx_drive_pos) |-> !tx_drive_neg)
		else $error("line skipped zero after positive");
	a_zero_after_neg: assert property ($fell(tx_drive_neg) |-> !tx_drive_pos)
		else $error("line skipped zero after negative");
	a_reset_quiet: assert property ($fell(rst) |-> !(tx_drive_pos || tx_drive_neg || fifo_overrun || check_error))
		else $error("outputs active right after reset");
	a_group_hold: assert property ($changed(check_nibble) |=> $stable(check_nibble) [*4])
		else $error("decoded group changed inside a slot");
	a_error_invalid: assert property (check_error |-> check_invalid)
		else $error("error group not marked invalid");
	a_invalid_no_data: assert property (check_invalid |-> check_nibble == NIB_ZERO)
		else $error("invalid group carries a nibble");

	c_neg_pulse: cover property ($rose(tx_drive_neg));
	c_error: cover property ($rose(check_error));
	c_overrun: cover property ($rose(fifo_overrun));
	c_top_nibble: cover property (check_nibble == 4'hF);
endmodule

bind fetx_top fetx_properties u_props (
	.sys_clk      (sys_clk),
	.rst          (rst),
	.tx_drive_pos (tx_drive_pos),
	.tx_drive_neg (tx_drive_neg),
	.fifo_overrun (fifo_overrun),
	.check_nibble (check_nibble),
	.check_invalid(check_invalid),
	.check_error  (check_error)
);

// [fetx_mac_model.sv]
// Purpose: MAC transmit side, nibble clock, data and enable
// Assumes: Nibble clock runs free; data launched on its rising edge
// Notes:   Half period adjustable so the buffer can be made to underrun
`timescale 1ns/1ps
module fetx_mac_model
	import fetx_pkg::*;
(
	// MII transmit side
	output logic                       mii_tx_clk,
	output logic [fetx_pkg::NIB_W-1:0] mii_txd,
	output logic                       mii_tx_en
);
	int half_ns = 32;

	initial begin
		mii_tx_clk = 1'b0;
		mii_txd    = 4'hA;
		mii_tx_en  = 1'b0;
	end

	always begin
		#(half_ns) mii_tx_clk = ~mii_tx_clk;
	end

	////////////////////////////////////////
	// Released data line flips so a stale nibble never looks valid
	task automatic send_frame(input logic [NIB_W-1:0] nibs[$]);
		foreach (nibs[i]) begin
			@(posedge mii_tx_clk);
			mii_tx_en <= 1'b1;
			mii_txd   <= nibs[i];
		end
		@(posedge mii_tx_clk);
		mii_tx_en <= 1'b0;
		mii_txd   <= ~mii_txd;
	endtask
endmodule

// [fetx_tb.sv]
// Purpose: Self-checking bench for the transmit coding path
// Assumes: Slot of two clocks per bit so 64 ns nibbles never underrun
// Notes:   Decoded groups are watched mid-slot; the line is counted
`timescale 1ns/1ps
module testbench;
	import fetx_pkg::*;
	localparam int BITC = 2;
	logic               sys_clk = 1'b0;
	logic               rst     = 1'b1;
	logic [STRAP_W-1:0] strap   = 5'h02;
	logic               bypass  = 1'b1;
	logic               mii_tx_clk;
	logic [NIB_W-1:0]   mii_txd;
	logic               mii_tx_en;
	logic               pos, neg, overrun, inval, err;
	logic [NIB_W-1:0]   nib;
	int                 miscompares = 0;
	int                 n_tests = 0;

	always begin
		#4 sys_clk = ~sys_clk;
	end

	fetx_mac_model mac (.mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

	fetx_top #(.BIT_CYCLES(BITC), .DEPTH(FIFO_DEPTH)) DUT (
		.sys_clk(sys_clk), .rst(rst), .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd),
		.mii_tx_en(mii_tx_en), .strap_address_input(strap), .scramble_bypass(bypass),
		.tx_drive_pos(pos), .tx_drive_neg(neg), .fifo_overrun(overrun),
		.check_nibble(nib), .check_invalid(inval), .check_error(err)
	);

	////////////////////////////////////////
	task automatic cmp_nib(input logic [NIB_W-1:0] got, input logic [NIB_W-1:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Straps settle through the synchroniser before the seed load
	task automatic do_reset(input logic [STRAP_W-1:0] s, input logic byp);
		@(posedge sys_clk);
		rst    <= 1'b1;
		strap  <= s;
		bypass <= byp;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	task automatic record(output logic [63:0] v);
		repeat (20) @(posedge sys_clk);
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk);
			v[2*i]   = pos;
			v[2*i+1] = neg;
		end
	endtask

	////////////////////////////////////////
	task automatic t_frame;
		logic [NIB_W-1:0] tx[$];
		int               k;
		tx = {4'h5, 4'h5};
		k  = 0;
		for (int i = 0; i < 16; i++) begin
			tx.push_back(NIB_W'(i));
		end
		fork
			mac.send_frame(tx);
			begin
				while (nib !== 4'h5 && k < 2000) begin
					@(posedge sys_clk);
					k++;
				end
				repeat (5) @(posedge sys_clk);
				tx = {tx, NIB_ZERO, NIB_ZERO, NIB_ZERO};
				foreach (tx[i]) begin
					cmp_nib(nib, tx[i], "decoded group");
					cmp_bit(inval, 1'b0, "invalid flag in frame");
					repeat (5*BITC) @(posedge sys_clk);
				end
			end
		join
		$display("frame test done");
	endtask

	task automatic t_idle_line;
		logic [7:0] np, nn;
		np = 8'h00;
		nn = 8'h00;
		repeat (80) begin
			@(posedge sys_clk);
			np += 8'(pos);
			nn += 8'(neg);
		end
		cmp_bit(np === 8'h14, 1'b1, "positive bits in bypassed idle");
		cmp_bit(nn === 8'h14, 1'b1, "negative bits in bypassed idle");
		$display("idle line test done");
	endtask

	task automatic t_halt;
		logic [NIB_W-1:0] tx[$];
		int               k;
		k  = 0;
		tx = {4'h5, 4'h5, 4'h3, 4'hC, 4'h9, 4'h6, 4'h1, 4'hE};
		// Nibble period longer than a slot, so the buffer runs dry
		mac.half_ns = 96;
		fork
			mac.send_frame(tx);
			begin
				while (err !== 1'b1 && k < 3000) begin
					@(posedge sys_clk);
					k++;
				end
				cmp_bit(err, 1'b1, "underrun halt flagged");
				cmp_bit(inval, 1'b1, "halt marked invalid");
				cmp_nib(nib, NIB_ZERO, "halt carries no data");
			end
		join
		mac.half_ns = 32;
		repeat (400) @(posedge sys_clk);
		$display("halt test done");
	endtask

	task automatic t_seed;
		logic [63:0] a, b, c;
		do_reset(5'h02, 1'b0);
		record(a);
		do_reset(5'h03, 1'b0);
		record(b);
		do_reset(5'h04, 1'b0);
		record(c);
		cmp_bit(a === b, 1'b1, "seed ignores strap bit 0");
		cmp_bit(a !== c, 1'b1, "seed follows straps");
		do_reset(5'h02, 1'b1);
		$display("seed test done");
	endtask

	task automatic t_overrun;
		logic [NIB_W-1:0] tx[$];
		int               k;
		k = 0;
		for (int i = 0; i < 200; i++) begin
			tx.push_back(NIB_W'(i));
		end
		cmp_bit(overrun, 1'b0, "overrun clear after reset");
		fork
			mac.send_frame(tx);
			begin
				while (overrun !== 1'b1 && k < 3000) begin
					@(posedge sys_clk);
					k++;
				end
				cmp_bit(overrun, 1'b1, "overrun on long frame");
			end
		join
		do_reset(5'h02, 1'b1);
		repeat (2) @(posedge sys_clk);
		cmp_bit(overrun, 1'b0, "overrun cleared by reset");
		$display("overrun test done");
	endtask

	////////////////////////////////////////
	initial begin
		#100000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_frame();
		t_idle_line();
		t_halt();
		t_seed();
		t_overrun();
		conclude();
	end
endmodule
